// [half_flash_conversion_bus_control_tb_top.sv]
// Purpose: Self-checking bench for the converter host controller
// Assumes: Converter model on the pins, pull-up on the shared pin
// Notes: Random codes and delays come from an LFSR seeded at 67
`timescale 1ns/1ps
`default_nettype none
module half_flash_conversion_bus_control_tb_top
  import hfcbc_pkg::*;
;
  logic ref_clk, nrst, startReq, modeSel, earlyRead, startReady, resultValid, timeoutErr;
  logic intN, rdyPullN, ovfN, rdyWire;
  logic [7:0] db, vin, rnd;
  logic [15:0] convCyc, rc;
  hfcbc_pins_out_t po;
  hfcbc_pins_in_t pi;
  hfcbc_result_t res;
  int num_errors = 0, checks_done = 0, cyc = 0;
  // Pull-up resolves the shared start/pending wire
  assign rdyWire = (po.wrOeN ? 1'b1 : po.wrOut) & rdyPullN;
  assign pi = {db, intN, rdyWire, ovfN};
  hfcbc_host uut (.ref_clk(ref_clk), .nrst(nrst), .startReq(startReq), .modeSel(modeSel),
    .earlyRead(earlyRead), .startReady(startReady), .pinsOut(po), .pinsIn(pi),
    .result(res), .resultValid(resultValid), .timeoutErr(timeoutErr));
  hfcbc_conv_model conv (.ref_clk(ref_clk), .selN(po.selN), .rdN(po.rdN), .wrLvl(rdyWire),
    .mode(po.mode), .vin(vin), .convCyc(convCyc), .resultBus(db), .intN(intN),
    .rdyPullN(rdyPullN), .overrangeFlagN(ovfN));
  // Expectation helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic expOver(input logic [7:0] v);
    return v == 8'hFF;
  endfunction : expOver
  // Only read-driven conversions longer than the guard may time out
  function automatic logic expGuard(input logic m, input logic [15:0] cc);
    return (m == MODE_RD) && (cc > {7'h00, GUARD_CYC});
  endfunction : expGuard
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  // One conversion; read-driven delays above the guard must flag a timeout
  task automatic run(input logic m, input logic e, input logic [7:0] v, input logic [15:0] cc);
    int n;
    n = 0;
    while (startReady !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    modeSel <= m;
    earlyRead <= e;
    vin <= v;
    convCyc <= cc;
    startReq <= 1'b1;
    @(posedge ref_clk);
    startReq <= 1'b0;
    while (resultValid !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    chk(resultValid === 1'b1, "no result");
    chk(timeoutErr === expGuard(m, cc), "guard flag");
    if (!expGuard(m, cc)) begin
      chk(res.code === v, "code");
      chk(res.overrange === expOver(v), "overrange");
    end
  endtask : run
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, far above twenty-one conversions
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  // Corner cases first, then random traffic
  initial begin
    nrst = 1'b0;
    startReq = 1'b0;
    modeSel = 1'b0;
    earlyRead = 1'b0;
    vin = 8'h00;
    convCyc = 16'h0001;
    rnd = 8'h43;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    run(1'b1, 1'b0, 8'hFF, 16'h0001);
    run(1'b1, 1'b1, 8'h00, 16'h0001);
    run(1'b0, 1'b0, 8'hFE, 16'h0001);
    run(1'b0, 1'b0, 8'h5A, 16'h0FA0);
    run(1'b0, 1'b1, 8'h81, 16'h0096);
    repeat (16) begin
      rnd = lfsr(rnd);
      rc = {9'h000, rnd[6:0]} + 16'h0001;
      rnd = lfsr(rnd);
      run(rc[2], rc[3], rnd, rc);
    end
    close_out();
  end
endmodule : half_flash_conversion_bus_control_tb_top
`default_nettype wire

// [hfcbc_conv_model.sv]
// Purpose: Behavioural converter facing the host pins
// Assumes: Sampled on ref_clk; vin is the code the analog input maps to
// Notes: Undriven data bus shows a rolling pattern stepping by 8'h35 each clock, not a held last value
`timescale 1ns/1ps
`default_nettype none
module hfcbc_conv_model #(
  parameter int TOUT_CYC = 80
) (
  input wire logic ref_clk,
  input wire logic selN,
  input wire logic rdN,
  input wire logic wrLvl,
  input wire logic mode,
  input wire logic [7:0] vin,
  input wire logic [15:0] convCyc,
  output logic [7:0] resultBus,
  output logic intN = 1'b1,
  output logic rdyPullN,
  output logic overrangeFlagN = 1'b1
);
  logic done = 1'b0, rdP = 1'b1, wrP = 1'b1, selP = 1'b1;
  logic [7:0] latchQ = 8'h00, noise = 8'h00;
  logic [15:0] cnt = 16'h0000;
  logic rdFall;
  // Pending pulls low from select until latched, no pull-up of its own
  assign rdyPullN = !(!mode && !selN && !done);
  // Bus driven only when selected and read; read-driven waits for completion
  assign resultBus = (!selN && !rdN && (mode || done)) ? latchQ : noise;
  assign rdFall = !selN && rdP && !rdN;
  // Conversion timing; cnt nonzero means converting
  always @(posedge ref_clk) begin
    rdP <= rdN;
    wrP <= wrLvl;
    selP <= selN;
    noise <= noise + 8'h35;
    if ((rdN && !rdP) || (selN && !selP)) begin
      intN <= 1'b1;
    end
    if (selN) begin
      cnt <= 16'h0000;
      done <= 1'b0;
    end else if (cnt == 16'h0001 || (cnt != 16'h0000 && mode && rdFall)) begin
      cnt <= 16'h0000;
      done <= 1'b1;
      intN <= 1'b0;
      latchQ <= vin;
      overrangeFlagN <= (vin != 8'hFF);
    end else if (mode && !wrP && wrLvl) begin
      cnt <= 16'(TOUT_CYC);
    end else if (!mode && rdFall && !done) begin
      cnt <= convCyc;
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end
  end
endmodule : hfcbc_conv_model
`default_nettype wire

// [hfcbc_host.sv]
// Purpose: Host controller that runs conversions on a half-flash converter via its pins.
// Assumes: Testbench resolves the shared WR/ready wire with a pull-up from wrOeN.
// Notes: Mode and early-read choice are taken when a start request is accepted.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Mode pin low gives read-driven, high gives write-then-read operation.
// - Write-then-read: select low, start strobe low begins the conversion.
// - Read-driven: select low, read strobe low starts the conversion.
// - Read-driven: pending release or a low completion flag ends the read.
// - Strobes ignored unless select is low; host selects every access.
module hfcbc_host
  import hfcbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic startReq,
  input wire logic modeSel,
  input wire logic earlyRead,
  output logic startReady,
  output hfcbc_pins_out_t pinsOut,
  input wire hfcbc_pins_in_t pinsIn,
  output hfcbc_result_t result,
  output logic resultValid,
  output logic timeoutErr
);

  hfcbc_state_t state_ff;
  hfcbc_state_t nxt_state;
  hfcbc_pins_in_t syncA_ff;
  hfcbc_pins_in_t syncB_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] guard_ff;
  logic mode_ff;
  logic early_ff;
  logic done_ff;
  logic intSeen_ff;
  logic convDone;
  logic cntHit;
  logic guardHit;
  hfcbc_pins_out_t pins_ff;
  hfcbc_result_t result_ff;
  logic valid_ff;
  logic err_ff;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_ff <= '1;
      syncB_ff <= '1;
    end else begin
      syncA_ff <= pinsIn;
      syncB_ff <= syncA_ff;
    end
  end

  // Completion seen: flag low, or pending released in read-driven mode
  always_comb begin
    if (mode_ff == MODE_RD) begin
      // Sync still shows the pulled-up idle level just after select falls
      convDone = (syncB_ff.readyIn || !syncB_ff.intN)
                 && (guard_ff > CNT_ONE);
    end else begin
      convDone = !syncB_ff.intN;
    end
  end

  assign cntHit = (cnt_ff == CNT_ONE);
  assign guardHit = (guard_ff == GUARD_CYC);

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff == CNT_ZERO) ? CNT_ZERO : cnt_ff - CNT_ONE;
    case (state_ff)
      HFCBC_IDLE: begin
        if (startReq) begin
          if (modeSel == MODE_WRRD) begin
            nxt_state = HFCBC_WRLO;
            nxt_cnt = WR_LOW_CYC;
          end else begin
            nxt_state = HFCBC_READ;
            nxt_cnt = CNT_ZERO;
          end
        end
      end
      HFCBC_WRLO: begin
        if (cntHit) begin
          nxt_state = HFCBC_WAIT;
          nxt_cnt = EARLY_CYC;
        end
      end
      HFCBC_WAIT: begin
        // Early read cuts the cycle short instead of waiting for the timeout
        if ((early_ff && cntHit) || convDone || guardHit) begin
          nxt_state = HFCBC_READ;
          nxt_cnt = ACCESS_CYC;
        end
      end
      HFCBC_READ: begin
        // Read-driven: hold the strobe until completion, then access time
        if (cnt_ff == CNT_ZERO) begin
          if (convDone || guardHit) begin
            nxt_cnt = ACCESS_CYC;
          end
        end else if (cntHit) begin
          nxt_state = HFCBC_DONE;
        end
      end
      HFCBC_DONE: begin
        nxt_state = HFCBC_RECOV;
        nxt_cnt = RECOV_CYC;
      end
      HFCBC_RECOV: begin
        // Flag must be back high before the next start
        if ((cnt_ff == CNT_ZERO) && syncB_ff.intN) begin
          nxt_state = HFCBC_IDLE;
        end
      end
      default: begin
        nxt_state = HFCBC_IDLE;
        nxt_cnt = CNT_ZERO;
      end
    endcase
  end

  // State and shared counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= HFCBC_IDLE;
      cnt_ff <= CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Guard counter; bounds waits well past the 1.5us conversion
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      guard_ff <= CNT_ZERO;
    end else if (state_ff == HFCBC_IDLE || state_ff == HFCBC_DONE) begin
      guard_ff <= CNT_ZERO;
    end else if (!guardHit) begin
      guard_ff <= guard_ff + CNT_ONE;
    end
  end

  // Options captured at start
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= MODE_RD;
      early_ff <= 1'b0;
    end else if (state_ff == HFCBC_IDLE && startReq) begin
      mode_ff <= modeSel;
      early_ff <= earlyRead;
    end
  end

  // Pin drive; select framed around every strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_ff.selN <= 1'b1;
      pins_ff.rdN <= 1'b1;
      pins_ff.wrOut <= 1'b1;
      pins_ff.wrOeN <= 1'b1;
      pins_ff.mode <= MODE_RD;
    end else begin
      pins_ff.mode <= (nxt_state == HFCBC_IDLE) ? pins_ff.mode : mode_ff;
      if (state_ff == HFCBC_IDLE && startReq) begin
        pins_ff.mode <= modeSel;
        pins_ff.wrOeN <= (modeSel == MODE_WRRD) ? 1'b0 : 1'b1; // Shared pin is ours only here
      end
      pins_ff.selN <= !(nxt_state == HFCBC_WRLO || nxt_state == HFCBC_WAIT
                        || nxt_state == HFCBC_READ);
      pins_ff.wrOut <= !(nxt_state == HFCBC_WRLO);
      pins_ff.rdN <= !(nxt_state == HFCBC_READ);
    end
  end

  // Sample data at the end of access, while the bus is still driven
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      if (state_ff == HFCBC_READ && cntHit) begin
        result_ff.code <= syncB_ff.resultBus;
        result_ff.overrange <= !syncB_ff.overrangeFlagN;
        valid_ff <= 1'b1;
      end
    end
  end

  // Completion seen during this conversion, for the error report
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      intSeen_ff <= 1'b0;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == HFCBC_DONE);
      if (state_ff == HFCBC_IDLE && startReq) begin
        intSeen_ff <= 1'b0;
        err_ff <= 1'b0;
      end else if (convDone && state_ff != HFCBC_RECOV) begin
        intSeen_ff <= 1'b1;
      end
      // Guard expiry without a completion is sticky until the next start
      if (guardHit && !convDone && !intSeen_ff) begin
        err_ff <= 1'b1;
      end
    end
  end

  assign pinsOut = pins_ff;
  assign result = result_ff;
  assign resultValid = valid_ff;
  assign timeoutErr = err_ff;
  assign startReady = (state_ff == HFCBC_IDLE);

endmodule : hfcbc_host

`default_nettype wire

// [hfcbc_host_sva.sv]
// Purpose: Pin protocol checks for the converter host
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into hfcbc_host
`timescale 1ns/1ps
`default_nettype none
module hfcbc_host_chk
  import hfcbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic startReq,
  input wire logic modeSel,
  input wire logic earlyRead,
  input wire logic startReady,
  input wire hfcbc_pins_out_t pinsOut,
  input wire hfcbc_pins_in_t pinsIn,
  input wire hfcbc_result_t result,
  input wire logic resultValid,
  input wire logic timeoutErr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Accepted start request
  wire logic take = startReq && startReady;
  // Start sequences on the pins
  mode_pin_a: assert property (take |=> pinsOut.mode == $past(modeSel))
    else $error("mode pin wrong");
  wr_start_a: assert property (take && modeSel |=> !pinsOut.selN && !pinsOut.wrOut && !pinsOut.wrOeN)
    else $error("write start wrong");
  rd_start_a: assert property (take && !modeSel |=> !pinsOut.selN && !pinsOut.rdN && pinsOut.wrOeN)
    else $error("read start wrong");
  wr_width_a: assert property ($fell(pinsOut.wrOut) && !pinsOut.wrOeN |-> ##59 !pinsOut.wrOut ##1 pinsOut.wrOut)
    else $error("start strobe width");
  early_rd_a: assert property (take && modeSel && earlyRead |-> ##[61:140] !pinsOut.rdN)
    else $error("early read late");
  // Strobes only under select, never together
  sel_cover_a: assert property (!pinsOut.rdN || (!pinsOut.wrOut && !pinsOut.wrOeN) |-> !pinsOut.selN)
    else $error("strobe without select");
  no_overlap_a: assert property (!(!pinsOut.wrOut && !pinsOut.wrOeN && !pinsOut.rdN))
    else $error("strobes overlap");
  // Bounded completion and clean restart
  valid_bound_a: assert property (take |-> ##[2:400] resultValid)
    else $error("no result in time");
  idle_int_a: assert property (take |-> pinsIn.intN)
    else $error("start with flag low");
  ready_drop_a: assert property (take |=> !startReady)
    else $error("start accepted while busy");
  cover property (take && modeSel && earlyRead);
  cover property (take && !modeSel);
  cover property ($rose(timeoutErr));
endmodule : hfcbc_host_chk
bind hfcbc_host hfcbc_host_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .startReq(startReq),
  .modeSel(modeSel), .earlyRead(earlyRead), .startReady(startReady), .pinsOut(pinsOut),
  .pinsIn(pinsIn), .result(result), .resultValid(resultValid), .timeoutErr(timeoutErr));
`default_nettype wire

// [hfcbc_pkg.sv]
// Purpose: Shared constants and types for the half-flash converter host controller.
// Assumes: Host clock ref_clk at 100 MHz; converter pins are asynchronous to it.
// Notes: Times are in ns; cycle counts derive from them.
package hfcbc_pkg;

  // Clock period
  localparam int CLK_NS = 10;

  // Host-chosen bus timings and converter timings, in ns
  localparam int WR_LOW_NS = 600;    // Start strobe low width
  localparam int TIMEOUT_INT_NS = 800; // Internal converter timeout
  localparam int EARLY_NS = 600;     // Early read, below the internal timeout
  localparam int ACCESS_NS = 250;    // Read strobe low until data is sampled
  localparam int CONV_NS = 1500;     // Full conversion cycle
  localparam int GUARD_NS = 3000;    // Give-up limit waiting for completion
  localparam int RECOV_NS = 500;     // Quiet time between conversions

  localparam int CNT_W = 9;
  localparam int DATA_W = 8;

  // Least time in whole cycles, never below one
  function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : ns2cyc

  localparam logic [CNT_W-1:0] WR_LOW_CYC = ns2cyc(WR_LOW_NS);
  localparam logic [CNT_W-1:0] EARLY_CYC = ns2cyc(EARLY_NS);
  localparam logic [CNT_W-1:0] ACCESS_CYC = ns2cyc(ACCESS_NS);
  localparam logic [CNT_W-1:0] GUARD_CYC = ns2cyc(GUARD_NS);
  localparam logic [CNT_W-1:0] RECOV_CYC = ns2cyc(RECOV_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

  // Mode pin levels
  localparam logic MODE_RD = 1'b0;   // Read-driven
  localparam logic MODE_WRRD = 1'b1; // Write-then-read

  // Controller states, Gray along the usual path except RECOV back to IDLE
  typedef enum logic [2:0] {
    HFCBC_IDLE = 3'h0,
    HFCBC_WRLO = 3'h1,
    HFCBC_WAIT = 3'h3,
    HFCBC_READ = 3'h2,
    HFCBC_DONE = 3'h6,
    HFCBC_RECOV = 3'h7
  } hfcbc_state_t;

  // Pins driven toward the converter
  typedef struct packed {
    logic selN;      // Device select
    logic rdN;       // Read strobe
    logic wrOut;     // Start strobe level on the shared WR/ready pin
    logic wrOeN;     // Low while the shared pin is driven
    logic mode;      // Mode select level
  } hfcbc_pins_out_t;

  // Pins read from the converter
  typedef struct packed {
    logic [DATA_W-1:0] resultBus;
    logic intN;           // Completion flag
    logic readyIn;        // Shared pin level, pending when low
    logic overrangeFlagN; // Overrange, active low
  } hfcbc_pins_in_t;

  // Finished conversion as handed to the user
  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic overrange;
  } hfcbc_result_t;

endpackage : hfcbc_pkg
